// ---- src/foc_pkg.sv ----
/*
 * Package of the flash command sequencer: register offsets, field layouts,
 * command codes, parameter slot figures and array geometry.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package foc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_INDEX  = 8'h04;
	localparam logic [7:0] ADDR_PARAM  = 8'h08;
	localparam logic [7:0] ADDR_PROT   = 8'h0c;
	localparam logic [7:0] ADDR_CTRL   = 8'h10;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int ST_COMPLETE = 7;
	localparam int ST_ACCESS_ERROR_FLAG   = 5;
	localparam int ST_PVIOL    = 4;
	localparam int ST_VERR     = 1;
	localparam int ST_VUNC     = 0;
	localparam int ST_SECURE   = 8;

	// Control register fields
	localparam int CT_NORMAL   = 0;
	localparam int CT_FAULT    = 1;
	localparam int CT_UNCORR   = 2;

	// Protection register fields
	localparam int PR_PROG_ALL = 0;
	localparam int PR_DATA_ALL = 1;
	localparam int PR_SECT_LO  = 8;

	// ----------------------------------------------------------------
	// Commands and parameter slots
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_OTP_PROG   = 8'h07;
	localparam logic [7:0] CMD_ERASE_ALL  = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLK  = 8'h09;
	localparam logic [7:0] CMD_ERASE_SECT = 8'h0a;

	localparam logic [2:0] SLOT_CMD   = 3'h0;
	localparam logic [2:0] SLOT_ADDR  = 3'h1;
	localparam logic [2:0] SLOT_LAST  = 3'h5;
	localparam int         NUM_SLOTS  = 6;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int         OTP_PHRASES   = 8;
	localparam logic [15:0] OTP_IDX_MAX  = 16'h0007;
	localparam logic [1:0] BLK_PROG      = 2'h0;
	localparam logic [1:0] BLK_DATA      = 2'h1;
	localparam int         SECT_BITS     = 9;
	localparam int         NUM_SECT_PROT = 8;
	localparam logic [15:0] ERASED_WORD  = 16'hffff;

	// Bus-cycle counts of the embedded operations
	localparam int T_CHECK = 4;
	localparam int T_PROG  = 16;
	localparam int T_ERASE = 64;
	localparam int T_VER   = 8;

	typedef enum logic [2:0] {
		S_IDLE,
		S_CHECK,
		S_PROG,
		S_ERASE,
		S_VERIFY
	} foc_state_t;

	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] w3;
	} foc_phrase_t;

	typedef struct packed {
		logic complete;
		logic access_error_flag;
		logic pviol;
		logic verr;
		logic vunc;
	} foc_flags_t;

endpackage

// ---- src/foc_seq.sv ----
/*
 * Flash command sequencer: one-time phrase programming, erase-all,
 * block erase and program-array sector erase, with launch checks,
 * protection checks, verify flags and security release.
 * Assumes a classic Wishbone master on clk_i, synchronous reset rst_i,
 * and that the array model outside signals verify faults via the control
 * register.
 */
// The Wishbone interface to the registers and the address map were left to the implementer.
// Contract
// - OTP writes only eight reserved unerasable phrases
// - OTP checks erased, programs, verifies, then completes
// - OTP index above seven gives access error
// - Program-array reads invalid during OTP
// - Second OTP on programmed phrase refused
// - OTP launch needs slot index five
// - Verify sets error and uncorrectable flags
// - Unavailable mode gives access error
// - Erase-all code, launch needs slot zero
// - Erase-all erases, verifies, then releases security unless verify signals a fault
// - Erase-all with protection sets violation
// - All-ones OTP phrase may be reprogrammed
// - Block erase erases, verifies, then completes
// - Block erase launch, block, alignment checks
// - Protected area in block sets violation
// - Sector erase clears whole addressed sector
// - Misaligned sector address gives access error
// - Protected sector sets violation
`timescale 1ns/1ps

module foc_seq #(
	parameter int SLOTS = foc_pkg::NUM_SLOTS
) (
	input  wire logic        clk_i,      // Bus clock
	input  wire logic        rst_i,      // Synchronous reset, active high
	input  wire logic        cyc_i,      // Wishbone cycle
	input  wire logic        stb_i,      // Wishbone strobe
	input  wire logic        we_i,       // Wishbone write enable
	input  wire logic [7:0]  adr_i,      // Wishbone byte address
	input  wire logic [3:0]  sel_i,      // Wishbone byte selects
	input  wire logic [31:0] dat_i,      // Wishbone write data
	output logic      [31:0] dat_o,      // Wishbone read data
	output logic             ack_o,      // Wishbone acknowledge
	input  wire logic        mode_ok_i,  // Commands allowed in current mode
	input  wire logic        prog_rd_i,  // Program-array read request
	output logic             rd_valid_o, // Program-array read data valid
	output logic             secure_o    // Device secured
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		foc_pkg::foc_state_t                 st;
		logic [7:0]                          cnt;
		logic [7:0]                          cmd;
		foc_pkg::foc_flags_t                 fl;
		logic [2:0]                          idx;
		logic [SLOTS-1:0][15:0]              prm;
		logic [foc_pkg::OTP_PHRASES-1:0][63:0] otp;
		logic [15:0]                         prot;
		logic [2:0]                          ctrl;
		logic                                secure;
		logic                                ack;
		logic [31:0]                         rdat;
	} foc_state_all_t;

	foc_state_all_t r;
	foc_state_all_t next_r;

	logic        bus_req;
	logic        wr;
	logic [2:0]  otp_sel;
	logic [1:0]  blk;
	logic [15:0] addr;
	logic        acc_err;
	logic        pv_err;
	logic        otp_blank;
	logic [63:0] wr_phrase;
	logic [2:0]  sect;

	assign bus_req   = cyc_i && stb_i && !r.ack;
	// Writes commit at the edge where the master samples ack high
	assign wr        = cyc_i && stb_i && we_i && r.ack;
	assign blk       = r.prm[foc_pkg::SLOT_CMD][1:0];
	assign addr      = r.prm[foc_pkg::SLOT_ADDR];
	assign otp_sel   = addr[2:0];
	assign otp_blank = (r.otp[otp_sel] == {4{foc_pkg::ERASED_WORD}});
	assign wr_phrase = {r.prm[2], r.prm[3], r.prm[4], r.prm[5]};
	assign sect      = addr[foc_pkg::SECT_BITS +: 3];

	// ----------------------------------------------------------------
	// Launch checks
	// ----------------------------------------------------------------
	always_comb begin
		acc_err = !mode_ok_i;
		pv_err  = 1'b0;
		case (r.prm[foc_pkg::SLOT_CMD][15:8])
			foc_pkg::CMD_OTP_PROG: begin
				if (r.idx != foc_pkg::SLOT_LAST)
					acc_err = 1'b1;
				if (addr > foc_pkg::OTP_IDX_MAX)
					acc_err = 1'b1;
				else if (!otp_blank)
					acc_err = 1'b1;
			end
			foc_pkg::CMD_ERASE_ALL: begin
				if (r.idx != foc_pkg::SLOT_CMD)
					acc_err = 1'b1;
				if (r.prot != 16'h0000)
					pv_err = 1'b1;
			end
			foc_pkg::CMD_ERASE_BLK: begin
				if (r.idx != foc_pkg::SLOT_ADDR)
					acc_err = 1'b1;
				if (blk == foc_pkg::BLK_PROG) begin
					if (addr[2:0] != 3'h0)
						acc_err = 1'b1;
					if (r.prot[foc_pkg::PR_PROG_ALL] || r.prot[15:foc_pkg::PR_SECT_LO] != 8'h00)
						pv_err = 1'b1;
				end else if (blk == foc_pkg::BLK_DATA) begin
					if (addr[0])
						acc_err = 1'b1;
					if (r.prot[foc_pkg::PR_DATA_ALL])
						pv_err = 1'b1;
				end else begin
					acc_err = 1'b1;
				end
			end
			foc_pkg::CMD_ERASE_SECT: begin
				if (r.idx != foc_pkg::SLOT_ADDR || blk != foc_pkg::BLK_PROG)
					acc_err = 1'b1;
				if (addr[2:0] != 3'h0)
					acc_err = 1'b1;
				if (r.prot[foc_pkg::PR_PROG_ALL] || r.prot[foc_pkg::PR_SECT_LO + 32'(sect)])
					pv_err = 1'b1;
			end
			default: acc_err = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r      = r;
		next_r.ack  = bus_req;
		next_r.rdat = r.rdat;
		if (bus_req && !we_i) begin
			case (adr_i)
				foc_pkg::ADDR_STATUS: next_r.rdat = {23'h0, r.secure, r.fl.complete, 1'b0,
					r.fl.access_error_flag, r.fl.pviol, 2'h0, r.fl.verr, r.fl.vunc};
				foc_pkg::ADDR_INDEX:  next_r.rdat = {29'h0, r.idx};
				foc_pkg::ADDR_PARAM:  next_r.rdat = (32'(r.idx) < SLOTS) ?
					{16'h0, r.prm[r.idx]} : 32'h0;
				foc_pkg::ADDR_PROT:   next_r.rdat = {16'h0, r.prot};
				foc_pkg::ADDR_CTRL:   next_r.rdat = {29'h0, r.ctrl};
				default:              next_r.rdat = 32'h0;
			endcase
		end
		if (r.st != foc_pkg::S_IDLE && r.cnt != 8'h00)
			next_r.cnt = r.cnt - 8'h01;

		case (r.st)
			foc_pkg::S_IDLE: begin
				if (wr) begin
					case (adr_i)
						foc_pkg::ADDR_STATUS: if (sel_i[0]) begin
							if (dat_i[foc_pkg::ST_ACCESS_ERROR_FLAG]) next_r.fl.access_error_flag = 1'b0;
							if (dat_i[foc_pkg::ST_PVIOL])  next_r.fl.pviol = 1'b0;
							if (dat_i[foc_pkg::ST_COMPLETE] && !r.fl.access_error_flag && !r.fl.pviol) begin
								next_r.fl.verr = 1'b0;
								next_r.fl.vunc = 1'b0;
								next_r.cmd     = r.prm[foc_pkg::SLOT_CMD][15:8];
								if (acc_err || pv_err) begin
									next_r.fl.access_error_flag = acc_err;
									next_r.fl.pviol  = pv_err;
								end else begin
									next_r.fl.complete = 1'b0;
									next_r.cnt         = 8'(foc_pkg::T_CHECK);
									next_r.st          = foc_pkg::S_CHECK;
								end
							end
						end
						foc_pkg::ADDR_INDEX: if (sel_i[0]) next_r.idx = dat_i[2:0];
						foc_pkg::ADDR_PARAM: if (32'(r.idx) < SLOTS && sel_i[1:0] == 2'h3)
							next_r.prm[r.idx] = dat_i[15:0];
						foc_pkg::ADDR_PROT: if (sel_i[1:0] == 2'h3) next_r.prot = dat_i[15:0];
						foc_pkg::ADDR_CTRL: if (sel_i[0]) next_r.ctrl = dat_i[2:0];
						default: ;
					endcase
				end
			end
			foc_pkg::S_CHECK: begin
				if (r.cnt == 8'h00) begin
					if (r.cmd == foc_pkg::CMD_OTP_PROG) begin
						if (otp_blank) begin
							next_r.cnt = 8'(foc_pkg::T_PROG);
							next_r.st  = foc_pkg::S_PROG;
						end else begin
							next_r.fl.access_error_flag   = 1'b1;
							next_r.fl.complete = 1'b1;
							next_r.st          = foc_pkg::S_IDLE;
						end
					end else begin
						next_r.cnt = 8'(foc_pkg::T_ERASE);
						next_r.st  = foc_pkg::S_ERASE;
					end
				end
			end
			foc_pkg::S_PROG: begin
				if (r.cnt == 8'h00) begin
					next_r.otp[otp_sel] = wr_phrase;
					next_r.cnt          = 8'(foc_pkg::T_VER);
					next_r.st           = foc_pkg::S_VERIFY;
				end
			end
			foc_pkg::S_ERASE: begin
				if (r.cnt == 8'h00) begin
					next_r.cnt = 8'(foc_pkg::T_VER);
					next_r.st  = foc_pkg::S_VERIFY;
				end
			end
			foc_pkg::S_VERIFY: begin
				if (r.cnt == 8'h00) begin
					if (r.ctrl[foc_pkg::CT_FAULT])
						next_r.fl.verr = 1'b1;
					if (r.ctrl[foc_pkg::CT_FAULT] && r.ctrl[foc_pkg::CT_UNCORR])
						next_r.fl.vunc = 1'b1;
					if (r.cmd == foc_pkg::CMD_ERASE_ALL && !r.ctrl[foc_pkg::CT_FAULT])
						next_r.secure = 1'b0;
					next_r.fl.complete = 1'b1;
					next_r.st          = foc_pkg::S_IDLE;
				end
			end
			default: next_r.st = foc_pkg::S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r             <= '0;
			r.st          <= foc_pkg::S_IDLE;
			r.fl.complete <= 1'b1;
			r.otp         <= '1;
			r.secure      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign dat_o      = r.rdat;
	assign ack_o      = r.ack;
	assign secure_o   = r.secure;
	assign rd_valid_o = prog_rd_i && !(r.st != foc_pkg::S_IDLE &&
		r.cmd == foc_pkg::CMD_OTP_PROG);

endmodule

// ---- tb/foc_seq_chk.sv ----
/* Port checker of the flash command sequencer, bound to foc_seq.
   Assumes one clock clk_i and a synchronous active-high reset rst_i. */
`timescale 1ns/1ps
module foc_seq_chk #(
	parameter int SLOTS = foc_pkg::NUM_SLOTS
) (
	input wire logic        clk_i,      // Bus clock
	input wire logic        rst_i,      // Sync reset
	input wire logic        cyc_i,      // Cycle
	input wire logic        stb_i,      // Strobe
	input wire logic        we_i,       // Write enable
	input wire logic [7:0]  adr_i,      // Address
	input wire logic [31:0] dat_i,      // Write data
	input wire logic        ack_o,      // Acknowledge
	input wire logic        prog_rd_i,  // Array read request
	input wire logic        rd_valid_o, // Array read valid
	input wire logic        secure_o    // Secured
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered next cycle");
	a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	a_rdv_gate: assert property (rd_valid_o |-> prog_rd_i)
		else $error("read valid without request");
	a_rdv_span: assert property ($fell(rd_valid_o) && $past(prog_rd_i) && prog_rd_i
		|=> (!rd_valid_o || !prog_rd_i) [*8]) else $error("otp busy too short");
	a_rdv_return: assert property ($rose(rd_valid_o) && $past(prog_rd_i, 8) && prog_rd_i
		|-> !$past(rd_valid_o, 8)) else $error("otp finished too soon");
	a_secure_rise: assert property ($rose(secure_o) |-> $past(rst_i))
		else $error("security set outside reset");
	a_secure_hold: assert property (ack_o && we_i && adr_i == foc_pkg::ADDR_STATUS &&
		dat_i[7] |=> $stable(secure_o) [*4]) else $error("security changed at launch");

	c_write: cover property (ack_o && we_i);
	c_unsecure: cover property ($fell(secure_o));
	c_otp_busy: cover property ($fell(rd_valid_o));
endmodule

bind foc_seq foc_seq_chk #(.SLOTS(SLOTS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
	.ack_o(ack_o), .prog_rd_i(prog_rd_i), .rd_valid_o(rd_valid_o), .secure_o(secure_o));

// ---- tb/tb.sv ----
/* Self-checking bench of the flash command sequencer over classic Wishbone.
   Assumes foc_pkg, foc_seq and the checker are compiled before it. */
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] OK = 32'h180, AE = 32'h1a0, PV = 32'h190;
	localparam logic [7:0]  OTP = foc_pkg::CMD_OTP_PROG, ALL = foc_pkg::CMD_ERASE_ALL;
	localparam logic [7:0]  BLK = foc_pkg::CMD_ERASE_BLK, SEC = foc_pkg::CMD_ERASE_SECT;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic        ack_o, rd_valid_o, secure_o, mode_ok_i = 1'b1, prog_rd_i = 1'b0;
	int          miscompares = 0, n_tests = 0, cycles = 0;
	logic [7:0]  codes[4] = '{OTP, ALL, BLK, SEC};
	int          lens[4] = '{6, 1, 2, 2};

	always #4 clk_i = ~clk_i;

	foc_seq u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.mode_ok_i(mode_ok_i), .prog_rd_i(prog_rd_i), .rd_valid_o(rd_valid_o),
		.secure_o(secure_o));

	task automatic final_report();
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	// Load n slots, clear flags, launch, poll until complete
	task automatic cmd(logic [7:0] code, logic [1:0] blk, logic [15:0] a, int n,
		logic [15:0] d, logic [31:0] exp);
		int polls = 0;
		for (int i = 0; i < n; i++) begin
			wb(1'b1, foc_pkg::ADDR_INDEX, 32'(i));
			wb(1'b1, foc_pkg::ADDR_PARAM, i == 0 ? {16'h0, code, 6'h0, blk} :
				(i == 1 ? {16'h0, a} : {16'h0, d}));
		end
		wb(1'b1, foc_pkg::ADDR_STATUS, 32'h30);
		wb(1'b1, foc_pkg::ADDR_STATUS, 32'h80);
		@(negedge clk_i);
		check("rd_valid", 32'(rd_valid_o), 32'(!(code == OTP && exp[5:4] == 2'b00)));
		do begin
			wb(1'b0, foc_pkg::ADDR_STATUS, 32'h0);
			polls++;
		end while (rd[7] !== 1'b1);
		check("status", rd, exp);
		check("busy", 32'(polls > 1), 32'(exp[5:4] == 2'b00));
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, foc_pkg::ADDR_STATUS, 32'h0);
		check("status", rd, OK);
		check("rd_valid", 32'(rd_valid_o), 32'h0);
		foreach (lens[k]) begin
			wb(1'b0, 8'(8'h04 + 8'(k) * 8'h04), 32'h0);
			check("reg", rd, 32'h0);
		end
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		prog_rd_i <= 1'b1;
		cmd(OTP, 2'h0, 16'h0008, 6, 16'h1234, AE);
		cmd(OTP, 2'h0, 16'h0003, 5, 16'h1234, AE);
		cmd(OTP, 2'h0, 16'h0007, 6, 16'h5a5a, OK);
		cmd(OTP, 2'h0, 16'h0007, 6, 16'h5a5a, AE);
		cmd(OTP, 2'h0, 16'h0000, 6, 16'h0001, OK);
		cmd(OTP, 2'h0, 16'h0002, 6, 16'hffff, OK);
		cmd(OTP, 2'h0, 16'h0002, 6, 16'h0f0f, OK);
		cmd(OTP, 2'h0, 16'h0002, 6, 16'h0f0f, AE);
		mode_ok_i <= 1'b0;
		foreach (codes[k]) cmd(codes[k], 2'h0, 16'h0000, lens[k], 16'h0, AE);
		mode_ok_i <= 1'b1;
		cmd(ALL, 2'h0, 16'h0000, 2, 16'h0, AE);
		cmd(BLK, 2'h0, 16'h0000, 1, 16'h0, AE);
		cmd(BLK, 2'h2, 16'h0000, 2, 16'h0, AE);
		cmd(BLK, 2'h0, 16'h0004, 2, 16'h0, AE);
		cmd(BLK, 2'h1, 16'h0001, 2, 16'h0, AE);
		cmd(BLK, 2'h1, 16'h0002, 2, 16'h0, OK);
		wb(1'b1, foc_pkg::ADDR_PROT, 32'h202);
		wb(1'b0, foc_pkg::ADDR_PROT, 32'h0);
		check("prot", rd, 32'h202);
		cmd(BLK, 2'h1, 16'h0000, 2, 16'h0, PV);
		cmd(ALL, 2'h0, 16'h0000, 1, 16'h0, PV);
		cmd(SEC, 2'h0, 16'h0200, 2, 16'h0, PV);
		cmd(SEC, 2'h0, 16'h0401, 2, 16'h0, AE);
		cmd(SEC, 2'h0, 16'h0408, 2, 16'h0, OK);
		wb(1'b1, foc_pkg::ADDR_PROT, 32'h0);
		wb(1'b1, foc_pkg::ADDR_CTRL, 32'h2);
		cmd(SEC, 2'h0, 16'h0bf8, 2, 16'h0, 32'h182);
		wb(1'b1, foc_pkg::ADDR_CTRL, 32'h6);
		cmd(BLK, 2'h0, 16'h0000, 2, 16'h0, 32'h183);
		wb(1'b1, foc_pkg::ADDR_CTRL, 32'h2);
		cmd(ALL, 2'h0, 16'h0000, 1, 16'h0, 32'h182);
		check("secure", 32'(secure_o), 32'h1);
		wb(1'b1, foc_pkg::ADDR_CTRL, 32'h0);
		cmd(ALL, 2'h0, 16'h0000, 1, 16'h0, 32'h080);
		check("secure", 32'(secure_o), 32'h0);
		cmd(OTP, 2'h0, 16'h0007, 6, 16'h0000, 32'h0a0);
		cmd(OTP, 2'h0, 16'h0005, 6, 16'h3c3c, 32'h080);
		final_report();
	end
endmodule
